// *** verilog/mxi_pkg.sv ***
package mxi_pkg;

  localparam int NOUT = 7;
  localparam int NRDY = 12;
  localparam int DW   = 18;
  localparam int AW   = 11;
  localparam int SW   = 4;

  // Address field X[1-11] of the function 15 instructions
  localparam logic [AW-1:0] ADDR_RAW  = 11'h040;
  localparam logic [AW-1:0] ADDR_SRC  = 11'h041;
  localparam logic [AW-1:0] ADDR_MSET = 11'h040;
  localparam logic [AW-1:0] ADDR_MCLR = 11'h041;
  localparam logic [AW-1:0] UNIT_STEP = 11'h002;

  // Address bits 3-6 reach outlet A only
  localparam logic [AW-1:0] ADDR_A_ONLY = 11'h03c;

  localparam logic [NRDY-1:0] MASK_RST = 12'h000;

  // Position of extension signal 4 (ready Z of outlet A)
  localparam int EXT_Z_LO = 3;
  // Outlets whose ready Y feed the second OR gate (C to G)
  localparam int Y_OR_LO  = 2;
  // Outlets whose ready X feed interrupt 1 (A to C)
  localparam int X_INT_HI = 2;
  // Outlets whose ready Y feed interrupt 1 (A and B)
  localparam int Y_INT_HI = 1;

  localparam int INT_1 = 0;
  localparam int INT_2 = 1;
  localparam int INT_3 = 2;

  typedef struct packed {
    logic [DW-1:0] data_out;
    logic [AW-1:0] addr;
    logic          in_sel;
    logic          out_sel;
    logic          last_word;
    logic          reset;
    logic          power_on;
    logic          auto_run;
    logic          mains_fail;
  } mxi_dn_s;

  typedef struct packed {
    logic [DW-1:0] data_in;
    logic          reply;
    logic          block_xfer;
  } mxi_up_s;

endpackage

// *** verilog/mxi_unit.sv ***
`timescale 1ns/1ps
// Summary of operation
// - Processor signals are repeated on every outlet; outlets B to G get address bits 3-6, auto_run and mains_fail held low.
// - Non-ready, non-interrupt outlet signals are ORed to the processor.
// - Twelve mask-gated ready lines are ORed onto one processor interrupt.
// - An unmasked OR combines five more readies (Y of C to G) onto another interrupt.
// - The group interrupt is high while an active line has its mask bit set.
// - Input 64 returns live states of lines 1 to 12, whatever the mask holds.
// - Input 65 returns the top active line number, line 1 first, 0 if none.
// - Masked-off lines do not count toward the number read by input 65.
// - Output 4160 sets every mask bit whose accumulator bit is one.
// - Output 4161 clears every mask bit whose accumulator bit is one.
// - Mask bits facing accumulator zeros are left alone by set and clear.
// - The whole mask is cleared by the computer reset.
// - Interrupts and outlet readies meet at one patch point for rerouting.
// - Up to seven outlets replicate the processor direct interface.
module mxi_unit
  import mxi_pkg::*;
#(
  parameter logic SECOND_UNIT = 1'b0
)
(
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire mxi_pkg::mxi_dn_s           cpu_dn,
  output      mxi_pkg::mxi_up_s           cpu_up,
  output      logic [2:0]                 cpu_int,
  output      mxi_pkg::mxi_dn_s [6:0]     outlet_dn,
  input  wire mxi_pkg::mxi_up_s [6:0]     outlet_up,
  input  wire logic [6:0]                 ready_x,
  input  wire logic [6:0]                 ready_y,
  input  wire logic [6:0]                 ready_z,
  input  wire logic [11:0]                patch_ext,
  output      logic [6:0]                 patch_rdy_x,
  output      logic [6:0]                 patch_rdy_y,
  output      logic [6:0]                 patch_rdy_z
);
  import mxi_pkg::*;

  mxi_dn_s             dn_s1, dn_s2;
  mxi_up_s [NOUT-1:0]  up_s1, up_s2;
  logic [NOUT-1:0]     rx_s1, rx_s2, ry_s1, ry_s2, rz_s1, rz_s2;
  logic [NRDY-1:0]     pe_s1, pe_s2;
  logic                out_sel_p_q;
  logic [NRDY-1:0]     mask_q, mask_d;
  logic [NRDY-1:0]     ext_w;
  logic [SW-1:0]       src_w;
  logic [AW-1:0]       ofs;
  logic                rd_raw, rd_src, wr_edge;
  mxi_up_s             or_up, up_d, up_q;
  mxi_dn_s [NOUT-1:0]  odn_q;
  logic [2:0]          int_q;
  logic [NOUT-1:0]     px_q, py_q, pz_q;

  // Two flops on every pin input except rst before any logic reads it
  always_ff @(posedge clk)
  begin
    dn_s1 <= cpu_dn;
    dn_s2 <= dn_s1;
    up_s1 <= outlet_up;
    up_s2 <= up_s1;
  end

  always_ff @(posedge clk)
  begin
    rx_s1 <= ready_x;
    rx_s2 <= rx_s1;
    ry_s1 <= ready_y;
    ry_s2 <= ry_s1;
    rz_s1 <= ready_z;
    rz_s2 <= rz_s1;
    pe_s1 <= patch_ext;
    pe_s2 <= pe_s1;
  end

  // Downstream repeat, address bits 3-6 only on outlet A
  genvar g;
  generate
    for (g = 0; g < NOUT; g++)
    begin : g_out
      always_ff @(posedge clk)
      begin
        if (rst)
          odn_q[g] <= '0;
        else
        begin
          odn_q[g] <= dn_s2;
          if (g != 0)
          begin
            odn_q[g].addr       <= dn_s2.addr & ~ADDR_A_ONLY;
            odn_q[g].auto_run   <= 1'b0;
            odn_q[g].mains_fail <= 1'b0;
          end
        end
      end
    end
  endgenerate

  always_comb
  begin
    or_up = '0;
    for (int i = 0; i < NOUT; i++)
      or_up = or_up | up_s2[i];
  end

  // Extension lines: patch inputs on all twelve, readies Z of A-G ORed onto 4-10
  always_comb
  begin
    ext_w = pe_s2;
    ext_w[EXT_Z_LO +: NOUT] = pe_s2[EXT_Z_LO +: NOUT] | rz_s2;
  end

  // Line 1 is bit 0 and wins; the loop runs low priority first
  always_comb
  begin
    src_w = '0;
    for (int i = NRDY - 1; i >= 0; i--)
      if (ext_w[i] && mask_q[i])
        src_w = SW'(i + 1);
  end

  assign ofs     = SECOND_UNIT ? UNIT_STEP : '0;
  assign rd_raw  = dn_s2.in_sel && dn_s2.addr == ADDR_RAW + ofs;
  assign rd_src  = dn_s2.in_sel && dn_s2.addr == ADDR_SRC + ofs;
  assign wr_edge = dn_s2.out_sel && !out_sel_p_q;

  always_comb
  begin
    up_d = or_up;
    if (rd_raw)
    begin
      up_d.data_in = or_up.data_in | DW'(ext_w);
      up_d.reply   = 1'b1;
    end
    else if (rd_src)
    begin
      up_d.data_in = or_up.data_in | DW'(src_w);
      up_d.reply   = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      up_q <= '0;
    else
      up_q <= up_d;
  end

  // Mask acts once per select, on its leading edge
  always_ff @(posedge clk)
  begin
    if (rst)
      out_sel_p_q <= 1'b0;
    else
      out_sel_p_q <= dn_s2.out_sel;
  end

  always_comb
  begin
    mask_d = mask_q;
    if (wr_edge && dn_s2.addr == ADDR_MSET + ofs)
      mask_d = mask_q | dn_s2.data_out[NRDY-1:0];
    else if (wr_edge && dn_s2.addr == ADDR_MCLR + ofs)
      mask_d = mask_q & ~dn_s2.data_out[NRDY-1:0];
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      mask_q <= MASK_RST;
    else
      mask_q <= mask_d;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      int_q <= '0;
    else
    begin
      int_q[INT_1] <= |rx_s2[X_INT_HI:0] | |ry_s2[Y_INT_HI:0];
      int_q[INT_2] <= |ry_s2[NOUT-1:Y_OR_LO];
      int_q[INT_3] <= |(ext_w & mask_q) | dn_s2.mains_fail;
    end
  end

  // Readies also leave on the patch connector
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      px_q <= '0;
      py_q <= '0;
      pz_q <= '0;
    end
    else
    begin
      px_q <= rx_s2;
      py_q <= ry_s2;
      pz_q <= rz_s2;
    end
  end

  assign cpu_up      = up_q;
  assign cpu_int     = int_q;
  assign outlet_dn   = odn_q;
  assign patch_rdy_x = px_q;
  assign patch_rdy_y = py_q;
  assign patch_rdy_z = pz_q;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic [1:0] live_q;
  always_ff @(posedge clk)
  begin
    if (rst)
      live_q <= '0;
    else if (live_q != 2'h3)
      live_q <= live_q + 2'h1;
  end

  sequence s_settled;
    live_q == 2'h3 && !$past(rst);
  endsequence

  property p_repeat;
    s_settled |-> outlet_dn[0].data_out == $past(cpu_dn.data_out, 3)
      && outlet_dn[6].addr == ($past(cpu_dn.addr, 3) & ~ADDR_A_ONLY);
  endproperty
  a_repeat: assert property (p_repeat)
    else $error("outlet does not repeat processor signals");

  property p_or_up;
    s_settled |-> ($past(outlet_up[3].data_in, 3) & ~cpu_up.data_in) == '0;
  endproperty
  a_or_up: assert property (p_or_up)
    else $error("outlet data lost from processor OR");

  property p_int2;
    s_settled |-> cpu_int[INT_2] == |($past(ready_y, 3) >> Y_OR_LO);
  endproperty
  a_int2: assert property (p_int2)
    else $error("second OR group mismatch");

  property p_int3_masked;
    (mask_q == '0 && !dn_s2.mains_fail)[*2] |-> !cpu_int[INT_3];
  endproperty
  a_int3_masked: assert property (p_int3_masked)
    else $error("grouped interrupt with all lines masked");

  property p_int3_on;
    (ext_w & mask_q) != '0 |=> cpu_int[INT_3];
  endproperty
  a_int3_on: assert property (p_int3_on)
    else $error("grouped interrupt missing");

  sequence s_rd_raw;
    rd_raw && or_up == '0;
  endsequence

  property p_rd_raw;
    s_rd_raw |=> cpu_up.reply && cpu_up.data_in == DW'($past(ext_w));
  endproperty
  a_rd_raw: assert property (p_rd_raw)
    else $error("raw ready read wrong");

  property p_src_none;
    rd_src && or_up == '0 && (ext_w & mask_q) == '0
      |=> cpu_up.reply && cpu_up.data_in == '0;
  endproperty
  a_src_none: assert property (p_src_none)
    else $error("source number not zero when idle");

  property p_src_first;
    rd_src && or_up == '0 && ext_w[1] && mask_q[1] && !mask_q[0]
      |=> cpu_up.data_in == DW'(2);
  endproperty
  a_src_first: assert property (p_src_first)
    else $error("masked line affected source number");

  property p_mset;
    wr_edge && dn_s2.addr == ADDR_MSET + ofs
      |=> mask_q == ($past(mask_q) | $past(dn_s2.data_out[NRDY-1:0]));
  endproperty
  a_mset: assert property (p_mset)
    else $error("mask set wrong");

  property p_mclr;
    wr_edge && dn_s2.addr == ADDR_MCLR + ofs
      |=> mask_q == ($past(mask_q) & ~$past(dn_s2.data_out[NRDY-1:0]));
  endproperty
  a_mclr: assert property (p_mclr)
    else $error("mask clear wrong");

  property p_mask_hold;
    !wr_edge |=> $stable(mask_q);
  endproperty
  a_mask_hold: assert property (p_mask_hold)
    else $error("mask changed without an instruction");

  property p_rst;
    @(posedge clk) disable iff (1'b0) rst |=> mask_q == MASK_RST;
  endproperty
  a_rst: assert property (p_rst)
    else $error("mask not cleared by reset");

endmodule

// *** tb/mxi_periph.sv ***
`timescale 1ns/1ps
module mxi_periph
  import mxi_pkg::*;
#(
  parameter logic [AW-1:0] PADDR = 11'h003,
  parameter logic [DW-1:0] PDATA = 18'h00001
)
(
  input  wire logic             clk,
  input  wire mxi_pkg::mxi_dn_s dn,
  output      mxi_pkg::mxi_up_s up
);
  mxi_up_s q = '0;
  logic    hit;
  assign hit = dn.in_sel && dn.addr == PADDR;
  // Idle lines sit low: any stuck bit would corrupt every ORed read
  always_ff @(posedge clk)
  begin
    q.reply <= hit;
    q.data_in <= hit ? PDATA : '0;
    q.block_xfer <= hit && PDATA[0];
  end
  assign up = q;
endmodule

// *** tb/mxi_unit_tb_top.sv ***
`timescale 1ns/1ps
module mxi_unit_tb_top;
  import mxi_pkg::*;
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  mxi_dn_s       dn = '0;
  mxi_up_s       up;
  logic [2:0]    irq;
  mxi_dn_s [6:0] odn;
  mxi_up_s [6:0] oup;
  logic [6:0]    rx = '0;
  logic [6:0]    ry = '0;
  logic [6:0]    rz = '0;
  logic [6:0]    pz;
  logic [6:0]    px;
  logic [6:0]    py;
  mxi_up_s       up2;
  logic          bx;
  logic [11:0]   pe = '0;
  logic [DW-1:0] rd;
  int            n_fail = 0;
  int            samples_checked = 0;

  always #2.5 clk = ~clk;

  mxi_unit dut_u (
    .clk(clk), .rst(rst), .cpu_dn(dn), .cpu_up(up), .cpu_int(irq),
    .outlet_dn(odn), .outlet_up(oup), .ready_x(rx), .ready_y(ry),
    .ready_z(rz), .patch_ext(pe), .patch_rdy_x(px), .patch_rdy_y(py),
    .patch_rdy_z(pz)
  );

  // Second unit shares every input pin; its own registers answer only at its offset addresses
  mxi_unit #(.SECOND_UNIT(1'b1)) dut2_u (
    .clk(clk), .rst(rst), .cpu_dn(dn), .cpu_up(up2), .cpu_int(),
    .outlet_dn(), .outlet_up(oup), .ready_x(rx), .ready_y(ry),
    .ready_z(rz), .patch_ext(pe), .patch_rdy_x(), .patch_rdy_y(),
    .patch_rdy_z()
  );

  for (genvar i = 0; i < 7; i++)
  begin : g_per
    mxi_periph #(.PADDR(11'h003), .PDATA(18'h1 << i)) per_u (
      .clk(clk), .dn(odn[i]), .up(oup[i])
    );
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [DW-1:0] e,
                     input logic [DW-1:0] g);
    samples_checked++;
    if (g !== e)
    begin
      $display("[FAIL] %s exp %h got %h", nm, e, g);
      n_fail++;
    end
  endtask

  task automatic settle;
    repeat (6) @(posedge clk);
    #1;
  endtask

  // Waits are bounded so a dead reply path ends the run instead of hanging
  task automatic wait_reply(input logic lvl);
    int k;
    k = 0;
    while (up.reply !== lvl && k < 20)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    if (up.reply !== lvl)
    begin
      $display("[FAIL] reply wait exp %b got %b", lvl, up.reply);
      n_fail++;
      conclude();
    end
  endtask

  task automatic rd_io(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge clk);
    dn.addr <= a;
    dn.in_sel <= 1'b1;
    wait_reply(1'b1);
    d = up.data_in;
    bx = up.block_xfer;
    @(posedge clk);
    dn.in_sel <= 1'b0;
    wait_reply(1'b0);
  endtask

  // Write acts on the leading edge of out_sel; keep it low long enough
  task automatic wr_io(input logic [AW-1:0] a, input logic [11:0] acc);
    @(posedge clk);
    dn.addr <= a;
    dn.data_out <= {6'h00, acc};
    dn.out_sel <= 1'b1;
    repeat (4) @(posedge clk);
    dn.out_sel <= 1'b0;
    settle();
  endtask

  logic [6:0] tx [3] = '{7'h04, 7'h00, 7'h00};
  logic [6:0] ty [3] = '{7'h00, 7'h04, 7'h02};
  logic [2:0] ti [3] = '{3'b001, 3'b010, 3'b001};

  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    pe <= 12'h803;
    rz <= 7'h41;
    settle();
    chk("int3 masked", 18'h0, irq[INT_3]);
    rd_io(ADDR_RAW, rd);
    chk("raw", 18'h00a0b, rd);
    rd_io(ADDR_SRC, rd);
    chk("src none", 18'h0, rd);
    chk("patch z", rz, pz);
    @(posedge clk);
    dn.addr <= ADDR_RAW + UNIT_STEP;
    dn.in_sel <= 1'b1;
    settle();
    chk("unit2 raw", 18'h00a0b, up2.data_in);
    chk("unit2 reply", 18'h1, up2.reply);
    chk("unit1 quiet", 18'h0, up.reply);
    @(posedge clk);
    dn.in_sel <= 1'b0;
    settle();
    $display("test reset done");
    wr_io(ADDR_MSET, 12'h208);
    chk("int3 set", 18'h1, irq[INT_3]);
    rd_io(ADDR_SRC, rd);
    chk("src 4", 18'h4, rd);
    wr_io(ADDR_MCLR, 12'h008);
    rd_io(ADDR_SRC, rd);
    chk("src 10", 18'ha, rd);
    wr_io(ADDR_MCLR, 12'h200);
    chk("int3 clr", 18'h0, irq[INT_3]);
    wr_io(ADDR_MSET, 12'h002);
    chk("int3 line2", 18'h1, irq[INT_3]);
    rd_io(ADDR_SRC, rd);
    chk("src 2", 18'h2, rd);
    // Reset in mid-run must drop a mask that is already set
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    settle();
    chk("int3 reset", 18'h0, irq[INT_3]);
    rd_io(ADDR_SRC, rd);
    chk("src reset", 18'h0, rd);
    $display("test mask done");
    @(posedge clk);
    dn.mains_fail <= 1'b1;
    dn.auto_run <= 1'b1;
    dn.data_out <= 18'h2a5c3;
    dn.addr <= 11'h07f;
    settle();
    chk("int3 mains", 18'h1, irq[INT_3]);
    chk("out a mains", 18'h1, odn[0].mains_fail);
    chk("out b mains", 18'h0, odn[1].mains_fail);
    chk("out g data", 18'h2a5c3, odn[6].data_out);
    chk("out a addr", 18'h07f, odn[0].addr);
    chk("out b addr", 18'h043, odn[1].addr);
    chk("out a auto", 18'h1, odn[0].auto_run);
    chk("out g auto", 18'h0, odn[6].auto_run);
    @(posedge clk);
    dn.mains_fail <= 1'b0;
    dn.auto_run <= 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk);
      rx <= tx[i];
      ry <= ty[i];
      settle();
      chk("int route", ti[i], irq);
      chk("patch x", tx[i], px);
      chk("patch y", ty[i], py);
    end
    $display("test routing done");
    rd_io(11'h003, rd);
    chk("or data", 18'h0007f, rd);
    chk("or block", 18'h1, bx);
    $display("test outlets done");
    conclude();
  end
endmodule
